// *** rtl/acs_done_signal.sv ***
// Completion flags, result words, interrupts and DMA requests
`timescale 1ns/1ps
module acs_done_signal
  import acs_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic norm_start,
  input wire logic hp_start,
  input wire logic res_valid,
  input wire logic res_hp,
  input wire logic [3:0] res_ch,
  input wire logic res_scan_last,
  input wire logic res_pos_err,
  input wire logic [DATA_W-1:0] res_data,
  output logic normal_busy_flag,
  output logic priority_busy_flag,
  output logic normal_done_irq,
  output logic priority_done_irq,
  output logic normal_dma_req,
  output logic priority_dma_req
);

  // Registers
  logic [CTRL_W-1:0] ctrl_ff;
  logic [1:0] dma_en_ff;
  logic eoc_ff;
  logic busy_ff;
  logic hp_eoc_ff;
  logic hp_busy_ff;
  logic [2:0] cnt_ff;
  logic irq_n_ff;
  logic irq_h_ff;
  logic [2:0] dpipe_n_ff;
  logic [2:0] dpipe_h_ff;
  logic [31:0] rdata_ff;
  logic [RES_W-1:0] res_ff [NUM_RES];

  // Next values
  logic [CTRL_W-1:0] nxt_ctrl;
  logic [1:0] nxt_dma_en;
  logic nxt_eoc;
  logic nxt_busy;
  logic nxt_hp_eoc;
  logic nxt_hp_busy;
  logic [2:0] nxt_cnt;
  logic nxt_irq_n;
  logic nxt_irq_h;
  logic [2:0] nxt_dpipe_n;
  logic [2:0] nxt_dpipe_h;
  logic [31:0] nxt_rdata;
  logic [RES_W-1:0] nxt_res [NUM_RES];

  acs_mode_t mode;
  logic [2:0] itm;
  logic norm_done;
  logic hp_done;
  logic norm_evt;
  logic slot_ok;
  logic dreq_n;
  logic dreq_h;
  logic ctrl_wr;
  logic dma_wr;
  logic st_rd;
  logic [3:0] wslot;
  logic [3:0] rslot;
  logic rd_res;

  // Result slot addressed by a bus address, or NUM_RES when none
  function automatic logic [3:0] res_slot(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - OFS_RES_BASE;
    if (a == OFS_RES_HP) begin
      res_slot = HP_SLOT;
    end else if (a >= OFS_RES_BASE && d[1:0] == 2'h0 &&
                 d[ADDR_W-1:2] < NUM_CH[ADDR_W-3:0]) begin
      res_slot = d[5:2];
    end else begin
      res_slot = 4'hd;
    end
  endfunction

  // Strobe qualified by one exact register address
  function automatic logic addr_hit(input logic stb,
                                    input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] ofs);
    addr_hit = stb && a == ofs;
  endfunction

  assign itm = ctrl_ff[CTRL_ITM_LO +: 3];
  assign mode = acs_mode_t'({ctrl_ff[CTRL_SCAN], ctrl_ff[CTRL_REPEAT]});
  assign norm_done = res_valid && !res_hp;
  assign hp_done = res_valid && res_hp;
  assign rslot = res_slot(reg_addr);
  assign rd_res = reg_rd && rslot != 4'hd;
  assign ctrl_wr = addr_hit(reg_wr, reg_addr, OFS_CTRL);
  assign dma_wr = addr_hit(reg_wr, reg_addr, OFS_DMA_EN);
  assign st_rd = addr_hit(reg_rd, reg_addr, OFS_STATUS);
  assign dreq_n = norm_evt && dma_en_ff[DMA_NORM];
  assign dreq_h = hp_done && dma_en_ff[DMA_HP];

  // Interrupt decision and storage slot for a normal completion
  always_comb begin
    norm_evt = 1'b0;
    wslot = res_ch;
    case (mode)
      ACS_FIXED_SINGLE: begin
        norm_evt = norm_done;
      end
      ACS_FIXED_REPEAT: begin
        wslot = {1'b0, cnt_ff};
        norm_evt = norm_done && cnt_ff == itm;
      end
      ACS_SCAN_SINGLE: begin
        norm_evt = norm_done && res_scan_last;
      end
      ACS_SCAN_REPEAT: begin
        norm_evt = norm_done;
      end
      default: begin
        norm_evt = 1'b0;
      end
    endcase
    if (res_hp) begin
      wslot = HP_SLOT;
    end
    slot_ok = wslot < NUM_RES[3:0];
  end

  // Software-written control and DMA enables
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_dma_en = dma_en_ff;
    if (ctrl_wr) begin
      nxt_ctrl = reg_wdata[CTRL_W-1:0];
    end
    if (dma_wr) begin
      nxt_dma_en = reg_wdata[1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_ff <= CTRL_RST;
      dma_en_ff <= DMA_EN_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
      dma_en_ff <= nxt_dma_en;
    end
  end

  // Completion and busy flags, fixed-repeat counter
  always_comb begin
    nxt_eoc = eoc_ff;
    nxt_busy = busy_ff;
    nxt_hp_eoc = hp_eoc_ff;
    nxt_hp_busy = hp_busy_ff;
    nxt_cnt = cnt_ff;
    if (st_rd) begin
      nxt_eoc = 1'b0;
      nxt_hp_eoc = 1'b0;
    end
    if (norm_done && mode == ACS_FIXED_REPEAT) begin
      nxt_cnt = (cnt_ff == itm) ? 3'h0 : cnt_ff + 3'h1;
    end
    if (norm_done) begin
      // Repeat modes keep busy until repeat is switched off
      if (!ctrl_ff[CTRL_REPEAT]) begin
        nxt_busy = 1'b0;
      end else begin
        nxt_busy = busy_ff;
      end
    end
    // Set wins over a clearing status read
    if (norm_evt) begin
      nxt_eoc = 1'b1;
    end
    if (norm_start) begin
      nxt_busy = 1'b1;
      nxt_eoc = 1'b0;
      nxt_cnt = 3'h0;
    end
    if (hp_done) begin
      nxt_hp_eoc = 1'b1;
      nxt_hp_busy = 1'b0;
    end
    if (hp_start) begin
      nxt_hp_busy = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      eoc_ff <= 1'b0;
      busy_ff <= 1'b0;
      hp_eoc_ff <= 1'b0;
      hp_busy_ff <= 1'b0;
      cnt_ff <= 3'h0;
    end else begin
      eoc_ff <= nxt_eoc;
      busy_ff <= nxt_busy;
      hp_eoc_ff <= nxt_hp_eoc;
      hp_busy_ff <= nxt_hp_busy;
      cnt_ff <= nxt_cnt;
    end
  end

  // Interrupt pulses and the DMA request delay lines
  always_comb begin
    nxt_irq_n = norm_evt;
    nxt_irq_h = hp_done;
    // Third stage puts each request two clocks after its interrupt
    nxt_dpipe_n = {dpipe_n_ff[1:0], dreq_n};
    nxt_dpipe_h = {dpipe_h_ff[1:0], dreq_h};
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_n_ff <= 1'b0;
      irq_h_ff <= 1'b0;
      dpipe_n_ff <= 3'h0;
      dpipe_h_ff <= 3'h0;
    end else begin
      irq_n_ff <= nxt_irq_n;
      irq_h_ff <= nxt_irq_h;
      dpipe_n_ff <= nxt_dpipe_n;
      dpipe_h_ff <= nxt_dpipe_h;
    end
  end

  // Read data stands one cycle after the strobe, zero otherwise
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == OFS_CTRL) begin
        nxt_rdata[CTRL_W-1:0] = ctrl_ff;
      end else if (reg_addr == OFS_STATUS) begin
        nxt_rdata[ST_EOC] = eoc_ff;
        nxt_rdata[ST_BUSY] = busy_ff;
        nxt_rdata[ST_HP_EOC] = hp_eoc_ff;
        nxt_rdata[ST_HP_BUSY] = hp_busy_ff;
      end else if (reg_addr == OFS_DMA_EN) begin
        nxt_rdata[1:0] = dma_en_ff;
      end else if (rd_res) begin
        nxt_rdata[RES_W-1:0] = res_ff[rslot];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Result words with their validity flags
  always_comb begin
    for (int i = 0; i < NUM_RES; i++) begin
      nxt_res[i] = res_ff[i];
      // Start clears the normal slots only
      if (norm_start && i != HP_SLOT) begin
        nxt_res[i][RES_OVR] = 1'b0;
        nxt_res[i][RES_STORED] = 1'b0;
      end
    end
    // Reading a result word consumes it
    if (rd_res) begin
      nxt_res[rslot][RES_OVR] = 1'b0;
      nxt_res[rslot][RES_STORED] = 1'b0;
    end
    // A fresh result wins over the read clear in the same cycle
    if (res_valid && slot_ok) begin
      nxt_res[wslot][DATA_W-1:0] = res_data;
      nxt_res[wslot][RES_OVR] = res_ff[wslot][RES_STORED] &&
        !(rd_res && rslot == wslot);
      nxt_res[wslot][RES_STORED] = 1'b1;
      nxt_res[wslot][RES_POSW] = res_pos_err;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_RES; i++) begin
        res_ff[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_RES; i++) begin
        res_ff[i] <= nxt_res[i];
      end
    end
  end

  assign reg_rdata = rdata_ff;
  assign normal_busy_flag = busy_ff;
  assign priority_busy_flag = hp_busy_ff;
  assign normal_done_irq = irq_n_ff;
  assign priority_done_irq = irq_h_ff;
  assign normal_dma_req = dpipe_n_ff[2];
  assign priority_dma_req = dpipe_h_ff[2];

endmodule

// *** rtl/acs_pkg.sv ***
// Constants and types for the converter completion signalling block
package acs_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 12;
  localparam int NUM_CH = 12;
  localparam int NUM_RES = 13;
  localparam logic [3:0] HP_SLOT = 4'hc;
  // Register byte addresses
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DMA_EN = 8'h08;
  localparam logic [7:0] OFS_RES_BASE = 8'h40;
  localparam logic [7:0] OFS_RES_HP = 8'h70;
  // Control register fields
  localparam int CTRL_REPEAT = 0;
  localparam int CTRL_SCAN = 1;
  localparam int CTRL_ITM_LO = 2;
  localparam int CTRL_W = 5;
  // Status register fields
  localparam int ST_EOC = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_HP_EOC = 2;
  localparam int ST_HP_BUSY = 3;
  // DMA enable fields
  localparam int DMA_NORM = 0;
  localparam int DMA_HP = 1;
  // Result word fields above the data
  localparam int RES_OVR = 12;
  localparam int RES_STORED = 13;
  localparam int RES_POSW = 14;
  localparam int RES_W = 15;
  // Reset values
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [1:0] DMA_EN_RST = 2'h0;
  // DMA delay after the interrupt, in system clocks
  localparam int DMA_DELAY_CLKS = 2;
  typedef enum logic [1:0] {
    ACS_FIXED_SINGLE,
    ACS_FIXED_REPEAT,
    ACS_SCAN_SINGLE,
    ACS_SCAN_REPEAT
  } acs_mode_t;
endpackage

// *** tb/acs_done_chk.sv ***
// Assertion checker for the completion signalling block
`timescale 1ns/1ps
module acs_done_chk
  import acs_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic norm_start,
  input wire logic hp_start,
  input wire logic res_valid,
  input wire logic res_hp,
  input wire logic res_scan_last,
  input wire logic normal_busy_flag,
  input wire logic priority_busy_flag,
  input wire logic normal_done_irq,
  input wire logic priority_done_irq,
  input wire logic normal_dma_req,
  input wire logic priority_dma_req
);
  logic [1:0] md_ff;
  logic [1:0] nxt_md;
  // Shadow of the scan and repeat bits
  always_comb begin
    nxt_md = md_ff;
    if (reg_wr && reg_addr == OFS_CTRL) nxt_md = reg_wdata[1:0];
  end
  always_ff @(posedge core_clk) md_ff <= sys_rst ? 2'h0 : nxt_md;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence norm_s; res_valid && !res_hp && !norm_start; endsequence
  sequence hp_s; res_valid && res_hp && !hp_start; endsequence
  dma_norm_a: assert property (
    normal_dma_req |-> $past(normal_done_irq, 2)) else $error("normal dma");
  dma_hp_a: assert property (
    priority_dma_req |-> $past(priority_done_irq, 2)) else $error("hp dma");
  norm_cause_a: assert property (
    normal_done_irq |-> $past(res_valid) && !$past(res_hp))
    else $error("normal irq without completion");
  hp_cause_a: assert property (
    priority_done_irq |-> $past(res_valid) && $past(res_hp))
    else $error("hp irq without completion");
  hp_done_a: assert property (
    hp_s |=> priority_done_irq && !priority_busy_flag) else $error("hp done");
  busy_hold_a: assert property (
    norm_s ##0 md_ff[0] && normal_busy_flag |=> normal_busy_flag)
    else $error("busy dropped in repeat");
  single_done_a: assert property (
    norm_s ##0 !md_ff[0] && (!md_ff[1] || res_scan_last)
    |=> normal_done_irq && !normal_busy_flag) else $error("single done");
  scan_quiet_a: assert property (
    norm_s ##0 md_ff == 2'h2 && !res_scan_last |=> !normal_done_irq)
    else $error("irq in mid scan");
endmodule
bind acs_done_signal acs_done_chk u_chk (.core_clk, .sys_rst, .reg_addr,
  .reg_wdata, .reg_wr, .norm_start, .hp_start, .res_valid, .res_hp,
  .res_scan_last, .normal_busy_flag, .priority_busy_flag,
  .normal_done_irq, .priority_done_irq, .normal_dma_req,
  .priority_dma_req);

// *** tb/acs_conv_model.sv ***
// Conversion source model that hands results to the block
`timescale 1ns/1ps
module acs_conv_model
  import acs_pkg::*;
(
  input wire logic core_clk,
  output logic res_valid,
  output logic res_hp,
  output logic [3:0] res_ch,
  output logic res_scan_last,
  output logic res_pos_err,
  output logic [DATA_W-1:0] res_data
);
  initial {res_valid, res_hp, res_ch, res_scan_last, res_pos_err} = '0;
  initial res_data = '0;
  task automatic comp(input logic h, input logic [3:0] c, input logic l,
                      input logic p, input logic [DATA_W-1:0] v);
    @(posedge core_clk);
    res_valid <= 1'b1;
    {res_hp, res_ch, res_scan_last, res_pos_err, res_data} <= {h, c, l, p, v};
    @(posedge core_clk);
    res_valid <= 1'b0;
    // Qualifiers go stale once released
    {res_hp, res_ch, res_scan_last, res_pos_err, res_data} <= ~{h, c, l, p, v};
  endtask
endmodule

// *** tb/acs_done_signal_test.sv ***
// Self-checking bench for the completion signalling block
`timescale 1ns/1ps
module acs_done_signal_test
  import acs_pkg::*;
;
  logic core_clk = 0;
  logic sys_rst = 1;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic norm_start = 0;
  logic hp_start = 0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic [31:0] reg_rdata;
  logic res_valid, res_hp, res_scan_last, res_pos_err;
  logic [3:0] res_ch;
  logic [DATA_W-1:0] res_data;
  logic normal_busy_flag, priority_busy_flag, normal_done_irq;
  logic priority_done_irq, normal_dma_req, priority_dma_req;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  int ni = 0, pi = 0, nd = 0, pd = 0, en = 0;
  acs_done_signal uut (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .norm_start, .hp_start, .res_valid, .res_hp,
    .res_ch, .res_scan_last, .res_pos_err, .res_data, .normal_busy_flag,
    .priority_busy_flag, .normal_done_irq, .priority_done_irq,
    .normal_dma_req, .priority_dma_req);
  acs_conv_model cm (.core_clk, .res_valid, .res_hp, .res_ch,
    .res_scan_last, .res_pos_err, .res_data);
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    ni += int'(normal_done_irq === 1'b1);
    pi += int'(priority_done_irq === 1'b1);
    nd += int'(normal_dma_req === 1'b1);
    pd += int'(priority_dma_req === 1'b1);
    if (cyc == 5000) begin
      fails++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Whole-word read, data compared in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(reg_rdata, e);
  endtask
  task automatic st(input bit h);
    @(posedge core_clk);
    if (h) hp_start <= 1'b1;
    else norm_start <= 1'b1;
    @(posedge core_clk);
    hp_start <= 1'b0;
    norm_start <= 1'b0;
  endtask
  task automatic settle();
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic t_regs();
    rd(OFS_CTRL, 32'h0);
    rd(OFS_STATUS, 32'h0);
    rd(OFS_DMA_EN, 32'h0);
    wr(OFS_DMA_EN, 32'h3);
    rd(OFS_DMA_EN, 32'h3);
    @(negedge core_clk);
    chk(reg_rdata, 32'h0);
    rd(8'h3c, 32'h0);
  endtask
  task automatic t_single();
    st(0);
    rd(OFS_STATUS, 32'h2);
    cm.comp(0, 4'h5, 0, 0, 12'h5a5);
    settle();
    en++;
    chk(32'(ni), 32'(en));
    chk(32'(nd), 32'h1);
    rd(OFS_STATUS, 32'h1);
    rd(OFS_STATUS, 32'h0);
    rd(OFS_RES_BASE + 8'h14, 32'h25a5);
    rd(OFS_RES_BASE + 8'h14, 32'h05a5);
  endtask
  task automatic t_hp();
    wr(OFS_DMA_EN, 32'h2);
    st(0);
    cm.comp(0, 4'h1, 0, 0, 12'h0);
    settle();
    en++;
    chk(32'(nd), 32'h1);
    st(1);
    @(negedge core_clk);
    chk({31'h0, priority_busy_flag}, 32'h1);
    cm.comp(1, 4'h0, 0, 1, 12'h123);
    settle();
    chk(32'(pi), 32'h1);
    chk(32'(pd), 32'h1);
    rd(OFS_STATUS, 32'h5);
    rd(OFS_STATUS, 32'h0);
    rd(OFS_RES_HP, 32'h6123);
  endtask
  task automatic t_rep();
    for (int m = 0; m < 8; m++) begin
      wr(OFS_CTRL, 32'(m * 4 + 1));
      st(0);
      for (int k = 0; k < 2 * m + 2; k++) cm.comp(0, 0, 0, 0, 12'(k));
      settle();
      en += 2;
      chk(32'(ni), 32'(en));
      rd(OFS_STATUS, 32'h3);
    end
    wr(OFS_CTRL, 32'h0);
    @(negedge core_clk);
    chk(32'(normal_busy_flag), 32'h1);
    cm.comp(0, 0, 0, 0, 12'h0);
    settle();
    en++;
    chk(32'(normal_busy_flag), 32'h0);
  endtask
  task automatic t_scan();
    wr(OFS_CTRL, 32'h2);
    st(0);
    cm.comp(0, 4'h3, 0, 0, 12'h0);
    cm.comp(0, 4'h4, 0, 0, 12'h0);
    settle();
    chk(32'(ni), 32'(en));
    cm.comp(0, 4'h5, 1, 0, 12'h0);
    settle();
    en++;
    chk(32'(ni), 32'(en));
    rd(OFS_STATUS, 32'h1);
  endtask
  task automatic t_srep();
    wr(OFS_DMA_EN, 32'h1);
    wr(OFS_CTRL, 32'h3);
    st(0);
    cm.comp(0, 4'h7, 0, 0, 12'h111);
    @(negedge core_clk);
    chk({31'h0, normal_done_irq}, 32'h1);
    @(negedge core_clk);
    chk({31'h0, normal_dma_req}, 32'h0);
    @(negedge core_clk);
    chk({31'h0, normal_dma_req}, 32'h1);
    cm.comp(0, 4'h7, 1, 0, 12'h222);
    settle();
    en += 2;
    chk(32'(ni), 32'(en));
    chk(32'(nd), 32'h3);
    rd(OFS_STATUS, 32'h3);
    rd(OFS_RES_BASE + 8'h1c, 32'h3222);
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_single();
    t_hp();
    t_rep();
    t_scan();
    t_srep();
    finish_test();
  end
endmodule
